// [hw/see_pkg.sv]
// Shared constants, types and helper functions for the serial memory link
package see_pkg;

  // Fixed device-type pattern in the upper nibble of the device address word
  localparam logic [3:0]  DEV_TYPE_CODE  = 4'ha;
  localparam int          ADDR_W         = 11;
  localparam int          MEM_BYTES      = 2048;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam logic [2:0]  BIT_MSB        = 3'h7;

  // Bus timing, master side
  localparam int          REF_PERIOD_NS  = 4;
  localparam int          SCL_PERIOD_NS  = 2500;
  // A quarter bit is a least time, so it rounds up
  localparam int          QUARTER_CYCLES = (SCL_PERIOD_NS + 4 * REF_PERIOD_NS - 1)
                                           / (4 * REF_PERIOD_NS);
  localparam logic [7:0]  QUARTER_LAST   = 8'(QUARTER_CYCLES - 1);

  // Self-timed program time, counted on the device's link clock
  localparam int          LINK_PERIOD_NS = 48;
  localparam int          SELF_TIMED_PROGRAM_TIME_MS = 10;
  localparam int          PROGRAM_TIME_NS = SELF_TIMED_PROGRAM_TIME_MS * 1000000;
  localparam int          PROGRAM_CYCLES = PROGRAM_TIME_NS / LINK_PERIOD_NS;
  localparam int          BUSY_W         = 18;

  // Master command codes
  typedef enum logic [2:0]
  {
    OP_START   = 3'h0,
    OP_STOP    = 3'h1,
    OP_WRITE   = 3'h2,
    OP_READ    = 3'h3,
    OP_RECOVER = 3'h4
  } see_op_type;

  // Capacity decoding: array address mask
  function automatic logic [ADDR_W-1:0] see_addr_mask(input int kbit);
    see_addr_mask = ADDR_W'(kbit * 128 - 1);
  endfunction

  // Capacity decoding: in-page address bits
  function automatic logic [ADDR_W-1:0] see_page_mask(input int kbit);
    see_page_mask = (kbit <= 2) ? 11'h007 : 11'h00f;
  endfunction

  // Capacity decoding: which strap bits are compared
  function automatic logic [2:0] see_cs_mask(input int kbit);
    if (kbit <= 2)
      see_cs_mask = 3'h7;
    else if (kbit == 4)
      see_cs_mask = 3'h6;
    else if (kbit == 8)
      see_cs_mask = 3'h4;
    else
      see_cs_mask = 3'h0;
  endfunction

endpackage

// [hw/see_link_if.sv]
// Two-wire link between master and memory device, with wired-AND data line
`timescale 1ns/1ps
interface see_link_if;
  logic scl;         // Clock, driven by the master
  logic m_sda_out;   // Master data value when enabled
  logic m_sda_oe_n;  // Master pull-down enable, low while driving
  logic d_sda_out;   // Device data value when enabled
  logic d_sda_oe_n;  // Device pull-down enable, low while driving
  logic sda;         // Resolved line level, pull-up when released

  // Pull-up wins unless some end pulls low
  assign sda = (m_sda_oe_n | m_sda_out) & (d_sda_oe_n | d_sda_out);

  modport master
  (
    output scl,
    output m_sda_out,
    output m_sda_oe_n,
    input  sda
  );

  modport device
  (
    input  scl,
    output d_sda_out,
    output d_sda_oe_n,
    input  sda
  );
endinterface

// [hw/see_master.sv]
// Byte-level two-wire bus master that makes the bus clock scl from ref_clk
`timescale 1ns/1ps
module see_master
  import see_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   sys_rst,
  see_link_if.master  link,
  input  wire logic   cmd_valid,
  input  see_op_type  cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic   cmd_ack,
  output logic        cmd_ready,
  output logic        rsp_valid,
  output logic [7:0]  rsp_data,
  output logic        rsp_nack
);

  // One-hot sequencer states
  typedef enum logic [4:0]
  {
    M_IDLE    = 5'h01,
    M_START   = 5'h02,
    M_STOP    = 5'h04,
    M_BYTE    = 5'h08,
    M_RECOVER = 5'h10
  } see_mstate_type;

  typedef struct packed
  {
    see_mstate_type state;     // Sequencer state
    logic [7:0]     div;       // Quarter-bit divider
    logic [1:0]     quarter;   // Quarter within a bit
    logic [3:0]     bit_cnt;   // Bit within the 9-clock byte
    logic [7:0]     shreg;     // Outgoing byte
    logic [7:0]     rx;        // Incoming byte
    logic           rd;        // Byte is a read
    logic           send_ack;  // Acknowledge a read byte
    logic           seen_high; // Recovery saw the line released
    logic           scl;       // Clock level driven out
    logic           sda_oe_n;  // Pull-down enable, low while driving
    logic           sda_m;     // Synchroniser first stage
    logic           sda_s;     // Synchronised line level
    logic           cmd_ready; // Ready for a command
    logic           rsp_valid; // Result pulse
    logic [7:0]     rsp_data;  // Result byte
    logic           rsp_nack;  // Line was high on the ninth clock
  } see_mst_type;

  // Synchroniser starts at the pull-up level of the released line
  localparam see_mst_type MST_RESET = '{state: M_IDLE, scl: 1'b1, sda_oe_n: 1'b1,
                                        sda_m: 1'b1, sda_s: 1'b1,
                                        cmd_ready: 1'b1, default: '0};

  see_mst_type st;        // Registered state
  see_mst_type next_st;   // Next state
  logic        tick;      // End of a quarter bit

  // Sequencer: each bit is four quarters, low-set, rise, sample, fall
  always_comb
  begin
    next_st           = st;
    next_st.sda_m     = link.sda;
    next_st.sda_s     = st.sda_m;
    next_st.rsp_valid = 1'b0;
    tick              = (st.div == QUARTER_LAST);
    next_st.div       = tick ? 8'h00 : st.div + 8'h01;
    if (st.state != M_IDLE && tick)
      next_st.quarter = st.quarter + 2'h1;
    case (st.state)
      M_IDLE:
      begin
        // Clock is parked where the last command left it
        if (cmd_valid)
        begin
          next_st.cmd_ready = 1'b0;
          next_st.div       = 8'h00;
          next_st.quarter   = 2'h0;
          next_st.bit_cnt   = 4'h0;
          next_st.shreg     = cmd_data;
          next_st.rd        = (cmd_op == OP_READ);
          next_st.send_ack  = cmd_ack;
          next_st.seen_high = 1'b0;
          next_st.rsp_nack  = 1'b0;
          if (cmd_op == OP_START)
            next_st.state = M_START;
          else if (cmd_op == OP_STOP)
            next_st.state = M_STOP;
          else if (cmd_op == OP_RECOVER)
            next_st.state = M_RECOVER;
          else
            next_st.state = M_BYTE;
        end
      end
      M_START:
      begin
        // Release, raise clock, pull data low while clock high, then low clock
        if (tick)
        begin
          if (st.quarter == 2'h0)
            next_st.sda_oe_n = 1'b1;
          else if (st.quarter == 2'h1)
            next_st.scl = 1'b1;
          else if (st.quarter == 2'h2)
            next_st.sda_oe_n = 1'b0;
          else
          begin
            next_st.scl       = 1'b0;
            next_st.state     = M_IDLE;
            next_st.cmd_ready = 1'b1;
            next_st.rsp_valid = 1'b1;
          end
        end
      end
      M_STOP:
      begin
        // Data low under low clock, raise clock, release data while high
        if (tick)
        begin
          if (st.quarter == 2'h0)
            next_st.sda_oe_n = 1'b0;
          else if (st.quarter == 2'h1)
            next_st.scl = 1'b1;
          else if (st.quarter == 2'h2)
            next_st.sda_oe_n = 1'b1;
          else
          begin
            next_st.state     = M_IDLE;
            next_st.cmd_ready = 1'b1;
            next_st.rsp_valid = 1'b1;
          end
        end
      end
      M_BYTE:
      begin
        if (tick)
        begin
          if (st.quarter == 2'h0)
          begin
            // Data changes only while the clock is low
            if (st.bit_cnt != BYTE_BITS)
              next_st.sda_oe_n = st.rd | st.shreg[7];
            else
              next_st.sda_oe_n = ~(st.rd & st.send_ack);
          end
          else if (st.quarter == 2'h1)
            next_st.scl = 1'b1;
          else if (st.quarter == 2'h2)
          begin
            if (st.bit_cnt != BYTE_BITS)
              next_st.rx = {st.rx[6:0], st.sda_s};
            else
              next_st.rsp_nack = st.sda_s;
          end
          else
          begin
            next_st.scl = 1'b0;
            if (st.bit_cnt != BYTE_BITS)
            begin
              next_st.shreg   = {st.shreg[6:0], 1'b0};
              next_st.bit_cnt = st.bit_cnt + 4'h1;
            end
            else
            begin
              next_st.state     = M_IDLE;
              next_st.cmd_ready = 1'b1;
              next_st.rsp_valid = 1'b1;
              next_st.rsp_data  = st.rx;
            end
          end
        end
      end
      M_RECOVER:
      begin
        // Clock with data released until it reads high, then a start
        if (tick)
        begin
          if (st.quarter == 2'h0)
            next_st.sda_oe_n = 1'b1;
          else if (st.quarter == 2'h1)
            next_st.scl = 1'b1;
          else if (st.quarter == 2'h2)
            next_st.seen_high = st.sda_s;
          else
          begin
            next_st.scl     = 1'b0;
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            if (st.seen_high || st.bit_cnt == BYTE_BITS)
            begin
              next_st.rsp_nack = ~st.seen_high;
              next_st.state    = M_START;
            end
          end
        end
      end
      default:
        next_st = MST_RESET;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= MST_RESET;
    else
      st <= next_st;
  end

  assign link.scl        = st.scl;
  assign link.m_sda_oe_n = st.sda_oe_n;
  assign link.m_sda_out  = 1'b0;
  assign cmd_ready       = st.cmd_ready;
  assign rsp_valid       = st.rsp_valid;
  assign rsp_data        = st.rsp_data;
  assign rsp_nack        = st.rsp_nack;

endmodule

// [hw/see_device.sv]
// Two-wire serial memory device: addressing, writes, reads and write cycle
`timescale 1ns/1ps
// Behaviour
// - Clock-high data fall starts every command
// - Data changes only under low clock
// - Clock-high data rise stops; stop after a read enters standby
// - Eight-bit words, device acks ninth clock
// - Standby at reset and after stop, once programming ends
// - Master recovers with up to nine clocks, then start
// - Device word begins with fixed type nibble
// - Straps compared per capacity, rest page bits
// - Page bits form upper word address
// - Last address bit selects read or write
// - Match acks, mismatch ignores transfer
// - Byte write ends with stop, starts programming
// - No response during self-timed write
// - Page write of eight or sixteen bytes
// - Write address wraps inside the page
// - Polling acked only after write completes
// - Counter holds last address plus one
// - Read address wraps over whole array
// - Current read sends byte at counter
// - Random read uses dummy write first
// - Master ack advances sequential read
module see_device
  import see_pkg::*;
#(
  parameter int DEV_KBIT         = 2,
  parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES
)
(
  input  wire logic   link_clk,
  input  wire logic   sys_rst,
  see_link_if.device  link,
  input  wire logic   chip_select_strap_high,
  input  wire logic   chip_select_strap_mid,
  input  wire logic   chip_select_strap_low,
  output logic        standby,
  output logic        write_busy
);

  localparam logic [ADDR_W-1:0] ADDR_MASK = see_addr_mask(DEV_KBIT);
  localparam logic [ADDR_W-1:0] PAGE_MASK = see_page_mask(DEV_KBIT);
  localparam logic [2:0]        CS_MASK   = see_cs_mask(DEV_KBIT);
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(PROGRAM_CYCLES_P);

  // One-hot protocol states
  typedef enum logic [5:0]
  {
    ST_IDLE  = 6'h01,
    ST_DEV   = 6'h02,
    ST_WORD  = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_RACK  = 6'h20
  } see_dstate_type;

  typedef struct packed
  {
    see_dstate_type    state;      // Protocol state
    logic              scl_m;      // Clock synchroniser first stage
    logic              scl_s;      // Synchronised clock
    logic              scl_p;      // Previous synchronised clock
    logic              sda_m;      // Data synchroniser first stage
    logic              sda_s;      // Synchronised data
    logic              sda_p;      // Previous synchronised data
    logic [2:0]        cs_m;       // Strap synchroniser first stage
    logic [2:0]        cs_s;       // Synchronised straps
    logic [3:0]        bit_cnt;    // Bits moved in this word
    logic [7:0]        shreg;      // Received word, or master ack in bit 0
    logic [ADDR_W-1:0] addr;       // Address counter
    logic [2:0]        page;       // Page bits from the device word
    logic              ack_phase;  // Device is acking this ninth clock
    logic              wr_pending; // Bytes stored since the last start
    logic [BUSY_W-1:0] busy_cnt;   // Self-timed program countdown
    logic              sda_oe_n;   // Pull-down enable, low while driving
    logic              standby;    // Idle with no internal work
    logic              busy;       // Program cycle running
  } see_dev_type;

  // Line stages start at the released level, so leaving reset shows no false edge
  localparam see_dev_type DEV_RESET = '{state: ST_IDLE, sda_oe_n: 1'b1, standby: 1'b1,
                                        scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                                        sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
                                        default: '0};

  see_dev_type       st;        // Registered state
  see_dev_type       next_st;   // Next state
  logic [7:0]        mem [MEM_BYTES];  // Array, sized for the largest capacity
  logic [7:0]        mem_rd;    // Byte at the counter
  logic              mem_we;    // Store a received byte
  logic              scl_rise;  // Clock rose
  logic              scl_fall;  // Clock fell
  logic              start_c;   // Start condition seen
  logic              stop_c;    // Stop condition seen
  logic              dev_match; // Device word addresses this part

  assign mem_rd = mem[st.addr];

  // Protocol engine, oversampling both wires on the link clock
  always_comb
  begin
    next_st       = st;
    next_st.scl_m = link.scl;
    next_st.scl_s = st.scl_m;
    next_st.scl_p = st.scl_s;
    next_st.sda_m = link.sda;
    next_st.sda_s = st.sda_m;
    next_st.sda_p = st.sda_s;
    next_st.cs_m  = {chip_select_strap_high, chip_select_strap_mid, chip_select_strap_low};
    next_st.cs_s  = st.cs_m;
    mem_we        = 1'b0;
    scl_rise      = st.scl_s & ~st.scl_p;
    scl_fall      = ~st.scl_s & st.scl_p;
    // Data edges under a high clock are framing, never data
    start_c       = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
    stop_c        = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
    dev_match     = (st.shreg[7:4] == DEV_TYPE_CODE)
                    && (((st.shreg[3:1] ^ st.cs_s) & CS_MASK) == 3'h0);
    if (st.busy_cnt != '0)
    begin
      // Inputs ignored while programming; a poll simply sees no ack
      next_st.busy_cnt = st.busy_cnt - 1'b1;
      next_st.state    = ST_IDLE;
      next_st.sda_oe_n = 1'b1;
    end
    else if (start_c)
    begin
      // A start aborts any transfer, including a repeated start mid-transfer; it cannot cut short programming
      next_st.state      = ST_DEV;
      next_st.bit_cnt    = 4'h0;
      next_st.ack_phase  = 1'b0;
      next_st.wr_pending = 1'b0;
      next_st.sda_oe_n   = 1'b1;
    end
    else if (stop_c)
    begin
      next_st.state    = ST_IDLE;
      next_st.sda_oe_n = 1'b1;
      if (st.wr_pending)
        next_st.busy_cnt = BUSY_LOAD;
      next_st.wr_pending = 1'b0;
    end
    else if (st.ack_phase)
    begin
      // Hold the ack low through the ninth clock; on its fall release, or drive the first bit of a read
      if (scl_fall)
      begin
        next_st.ack_phase = 1'b0;
        next_st.bit_cnt   = 4'h0;
        next_st.sda_oe_n  = (st.state == ST_RDATA) ? mem_rd[BIT_MSB] : 1'b1;
      end
    end
    else
    begin
      case (st.state)
        ST_IDLE:
          next_st.sda_oe_n = 1'b1;
        ST_DEV, ST_WORD, ST_WDATA:
        begin
          if (scl_rise && st.bit_cnt != BYTE_BITS)
          begin
            next_st.shreg   = {st.shreg[6:0], st.sda_s};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end
          else if (scl_fall && st.bit_cnt == BYTE_BITS)
          begin
            next_st.ack_phase = 1'b1;
            next_st.sda_oe_n  = 1'b0;
            if (st.state == ST_DEV)
            begin
              if (dev_match)
              begin
                next_st.page  = st.shreg[3:1] & ~CS_MASK;
                next_st.state = st.shreg[0] ? ST_RDATA : ST_WORD;
              end
              else
              begin
                next_st.ack_phase = 1'b0;
                next_st.sda_oe_n  = 1'b1;
                next_st.state     = ST_IDLE;
              end
            end
            else if (st.state == ST_WORD)
            begin
              next_st.addr  = {st.page, st.shreg} & ADDR_MASK;
              next_st.state = ST_WDATA;
            end
            else
            begin
              // Store now; only the low page bits count up
              mem_we             = 1'b1;
              next_st.wr_pending = 1'b1;
              next_st.addr       = (st.addr & ~PAGE_MASK)
                                   | ((st.addr + 1'b1) & PAGE_MASK);
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          else if (scl_fall && st.bit_cnt != BYTE_BITS)
            next_st.sda_oe_n = mem_rd[3'(BIT_MSB - st.bit_cnt[2:0])];
          else if (scl_fall)
          begin
            next_st.sda_oe_n = 1'b1;
            next_st.addr     = (st.addr + 1'b1) & ADDR_MASK;
            next_st.shreg    = 8'hff;
            next_st.bit_cnt  = 4'h0;
            next_st.state    = ST_RACK;
          end
        end
        ST_RACK:
        begin
          // Low on the ninth clock asks for the next byte
          if (scl_rise)
            next_st.shreg = {7'h00, st.sda_s};
          else if (scl_fall && !st.shreg[0])
          begin
            next_st.state    = ST_RDATA;
            next_st.sda_oe_n = mem_rd[BIT_MSB];
          end
          else if (scl_fall)
            next_st.state = ST_IDLE;
        end
        default:
          next_st = DEV_RESET;
      endcase
    end
    next_st.busy    = (next_st.busy_cnt != '0);
    next_st.standby = (next_st.state == ST_IDLE) && !next_st.busy;
  end

  // State register; reset enters standby with the line released
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= DEV_RESET;
    else
      st <= next_st;
  end

  // Array keeps contents across reset, as a nonvolatile store would
  always_ff @(posedge link_clk)
  begin
    if (mem_we)
      mem[st.addr] <= st.shreg;
  end

  assign link.d_sda_oe_n = st.sda_oe_n;
  assign link.d_sda_out  = 1'b0;
  assign standby         = st.standby;
  assign write_busy      = st.busy;

endmodule

// [testbench/see_link_assertions.sv]
// Concurrent checks on the two-wire link between master and memory device
`timescale 1ns/1ps
module see_link_assertions
  import see_pkg::*;
#(
  parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_out,
  input wire logic m_sda_oe_n,
  input wire logic d_sda_out,
  input wire logic d_sda_oe_n,
  input wire logic standby,
  input wire logic write_busy
);
  logic [BUSY_W-1:0] busy_cnt;  // Link cycles spent programming so far

  // Count programming time; a plain repetition would be far too long
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_cnt <= '0;
    else if (write_busy)
      busy_cnt <= busy_cnt + 1'b1;
    else
      busy_cnt <= '0;
  end

  dev_low_only_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !d_sda_oe_n |-> (!d_sda_out && !sda)) else $error("device drove the data line high");
  host_low_only_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !m_sda_oe_n |-> (!m_sda_out && !sda)) else $error("master drove the data line high");
  data_stable_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    (scl && $past(scl)) |-> $stable(d_sda_oe_n)) else $error("device data moved under high clock");
  busy_quiet_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    write_busy |-> d_sda_oe_n) else $error("device answered while programming");
  busy_standby_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    write_busy |-> !standby) else $error("standby during programming");
  busy_len_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    $fell(write_busy) |-> (busy_cnt >= PROGRAM_CYCLES_P - 1 && busy_cnt <= PROGRAM_CYCLES_P + 1))
    else $error("programming time off");
  busy_after_stop_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    $rose(write_busy) |-> (scl && sda)) else $error("programming began without a stop");
  standby_release_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    standby |-> d_sda_oe_n) else $error("device pulled data line in standby");

  // Main scenarios reached
  cover property (@(posedge link_clk) disable iff (sys_rst) $rose(write_busy));
  cover property (@(posedge link_clk) disable iff (sys_rst) scl && !d_sda_oe_n);
  cover property (@(posedge link_clk) disable iff (sys_rst) $rose(standby));
endmodule

// [testbench/tb.sv]
// Self-checking bench joining master and memory device across the link
`timescale 1ns/1ps
module tb
  import see_pkg::*;
;
  logic       ref_clk;     // Master clock, 4 ns
  logic       link_clk;    // Device clock, 48 ns
  logic       sys_rst;     // Shared reset
  logic       cmd_valid;   // Command offer
  see_op_type cmd_op;      // Command code
  logic [7:0] cmd_data;    // Byte to send
  logic       cmd_ack;     // Master ack on reads
  logic       cmd_ready;   // Master idle
  logic       rsp_valid;   // Command done pulse
  logic [7:0] rsp_data;    // Received or echoed byte
  logic       rsp_nack;    // Ninth-clock level
  logic [2:0] straps;      // Strap inputs
  logic [2:0] r;           // Strap value chosen
  logic       standby;     // Device idle
  logic       write_busy;  // Device programming
  logic [7:0] dw;          // Device word, write direction
  logic [7:0] pd [4];      // Page data
  logic [10:0] exp_q [$];  // Notes: check data, check nack, nack, data
  logic [10:0] me;         // Note being compared
  int         fail_count;  // Mismatches
  int         n_compared;  // Comparisons made

  see_link_if see_link_if_inst ();

  see_master see_master_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(see_link_if_inst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));

  // Short program time keeps the run small
  see_device #(.DEV_KBIT(2), .PROGRAM_CYCLES_P(200)) see_device_inst (.link_clk(link_clk),
    .sys_rst(sys_rst), .link(see_link_if_inst), .chip_select_strap_high(straps[2]),
    .chip_select_strap_mid(straps[1]), .chip_select_strap_low(straps[0]),
    .standby(standby), .write_busy(write_busy));

  see_link_assertions #(.PROGRAM_CYCLES_P(200)) see_link_assertions_inst (.ref_clk(ref_clk),
    .link_clk(link_clk), .sys_rst(sys_rst), .scl(see_link_if_inst.scl),
    .sda(see_link_if_inst.sda), .m_sda_out(see_link_if_inst.m_sda_out),
    .m_sda_oe_n(see_link_if_inst.m_sda_oe_n), .d_sda_out(see_link_if_inst.d_sda_out),
    .d_sda_oe_n(see_link_if_inst.d_sda_oe_n), .standby(standby), .write_busy(write_busy));

  // Clocks; the odd offset keeps the two edge sets apart
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // Verdict and end of run
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] x);
    n_compared++;
    if (got !== x)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, x);
    end
  endtask

  // Offer a command, note its expectation, wait bounded for the answer
  task automatic op(input see_op_type o, input logic [7:0] d, input logic a,
                    input logic [10:0] e);
    int i;
    exp_q.push_back(e);
    @(posedge ref_clk);
    cmd_op <= o;
    cmd_data <= d;
    cmd_ack <= a;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 8000 && rsp_valid !== 1'b1; i++)
      @(posedge ref_clk);
    if (i == 8000)
    begin
      fail_count++;
      $display("wrong value at %0t: no response", $time);
      summarize();
    end
  endtask

  // Byte out: the line echoes the byte, n is the expected ninth-clock level
  task automatic wr(input logic [7:0] d, input logic n);
    op(OP_WRITE, d, 1'b0, {2'b11, n, d});
  endtask

  // Byte in: expected data, and the master's own ack seen on the line
  task automatic rd(input logic a, input logic [7:0] x);
    op(OP_READ, 8'h00, a, {2'b11, ~a, x});
  endtask

  // Start or stop, nothing to compare
  task automatic bus(input see_op_type o);
    op(o, 8'h00, 1'b0, 11'h000);
  endtask

  // Pair each response with the oldest note
  always @(posedge ref_clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      me = (exp_q.size() == 0) ? 11'h7ff : exp_q.pop_front();
      if (me[10])
        chk(rsp_data, me[7:0]);
      if (me[9])
        chk({7'h00, rsp_nack}, {7'h00, me[8]});
      // The master must be free again in the cycle of its answer
      chk({7'h00, cmd_ready}, 8'h01);
    end
  end

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    straps = 3'h0;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(57));
    r = 3'($urandom);
    for (int k = 0; k < 4; k++)
      pd[k] = 8'($urandom);
    dw = {DEV_TYPE_CODE, r, 1'b0};
    @(posedge ref_clk);
    straps <= r;
    repeat (10) @(posedge link_clk);
    // Release on a master edge; the link clock never shares an edge with it
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk({7'h00, standby}, 8'h01);
    op(OP_RECOVER, 8'h00, 1'b0, {3'b010, 8'h00});
    wr({DEV_TYPE_CODE, ~r, 1'b0}, 1'b1);
    bus(OP_STOP);
    bus(OP_START);
    wr(dw, 1'b0);
    wr(8'h07, 1'b0);
    for (int k = 0; k < 4; k++)
      wr(pd[k], 1'b0);
    bus(OP_STOP);
    chk({7'h00, write_busy}, 8'h01);
    chk({7'h00, standby}, 8'h00);
    bus(OP_START);
    wr(dw, 1'b1);
    bus(OP_STOP);
    bus(OP_START);
    wr(dw, 1'b0);
    wr(8'h00, 1'b0);
    bus(OP_START);
    wr(dw | 8'h01, 1'b0);
    rd(1'b1, pd[1]);
    rd(1'b0, pd[2]);
    bus(OP_STOP);
    repeat (100) @(posedge ref_clk);
    chk({7'h00, standby}, 8'h01);
    bus(OP_START);
    wr(dw | 8'h01, 1'b0);
    rd(1'b0, pd[3]);
    bus(OP_STOP);
    repeat (5) @(posedge ref_clk);
    chk(exp_q.size() == 0 ? 8'h00 : 8'h01, 8'h00);
    summarize();
  end
endmodule
